// [hdl/fasi_pkg.sv]
// constants for the framer channel alarm status and interrupt block
// assumes one framer clock domain and the 8-bit processor register port
package fasi_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned N_INSERT = 5;
    localparam int unsigned ALIGN_W = 13;
    localparam int unsigned N_STATUS = 6;

    // register addresses on the processor port
    localparam logic [ADDR_W-1:0] ADDR_ERR_INSERT = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_LATCHED = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h16;

    // status, latched and enable bit positions
    localparam int unsigned ST_LOS = 0;
    localparam int unsigned ST_OOF = 1;
    localparam int unsigned ST_AIS = 2;
    localparam int unsigned ST_RAI = 3;
    localparam int unsigned ST_IDLE = 4;
    localparam int unsigned ST_SEF = 5;
    localparam int unsigned ST_FRAME_ALIGNMENT_CHANGE = 7;
    localparam logic [DATA_W-1:0] LATCHED_MASK = 8'hbf;
    localparam logic [DATA_W-1:0] IRQ_EN_MASK = 8'hbf;

    // error insert control fields
    localparam int unsigned EI_BPV = 0;
    localparam int unsigned EI_EXZ = 1;
    localparam int unsigned EI_PPAR = 2;
    localparam int unsigned EI_CPPAR = 3;
    localparam int unsigned EI_FBIT = 4;
    localparam int unsigned EI_FTYPE_LO = 5;
    localparam int unsigned EI_FTYPE_HI = 6;
    localparam int unsigned EI_MODE = 7;

    // reset values
    localparam logic [DATA_W-1:0] EIC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IRQ_EN_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LATCHED_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

    // alarm criteria; 8'hc0 is 192 line bits
    localparam logic [7:0] LOS_BITS = 8'hc0;
    localparam int unsigned F_WIN = 16;
    localparam int unsigned F_ERR_LIMIT = 3;
    localparam int unsigned M_WIN = 4;
    localparam int unsigned M_ERR_LIMIT = 2;
    localparam logic [2:0] E3_BAD_FAS = 3'h4;
    localparam logic [2:0] E3_GOOD_FAS = 3'h3;

    typedef enum logic [1:0] {
        LOS_CLEAR,
        LOS_DECLARED,
        LOS_RELEASE_WIN
    } fasi_los_state_t;
endpackage

// [hdl/fasi_alarm_status_irq.sv]
// one framer channel: alarm status, change latches, interrupt, error insert
// assumes all inputs are synchronous to clk_i and that detector strobes
// are one-cycle pulses; the device-wide master enable arrives as a level
// Operation
// - mode 0: control bit rise inserts one error
// - mode 1: manual input rise inserts enabled errors
// - all control bits zero: never insert
// - status bits 0..5 follow live conditions
// - loss status valid only in dual-rail mode
// - remote alarm from X/Sa bits only
// - any status change sets its latch
// - writing one clears latch, zero keeps
// - interrupt when latch, enable, master all set
// - interrupt drops when any term clears
// - alignment change on resync sets bit 7
// - alignment latch sets only after new resync
// - enables bits 0-5,7, reset zero, 6 unused
// - loss after 192 zeros, clear window
// - DS3 frame loss by F/M bit errors
// - E3 frame loss 4 bad, 3 good
`timescale 1ns/1ns
`default_nettype none
module fasi_alarm_status_irq
    import fasi_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic reg_cs_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [fasi_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [fasi_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [fasi_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic dual_rail_mode_i,
    input wire logic e3_mode_i,
    input wire logic line_bit_valid_i,
    input wire logic line_bit_i,
    input wire logic line_exz_i,
    input wire logic f_bit_valid_i,
    input wire logic f_bit_err_i,
    input wire logic m_bit_valid_i,
    input wire logic m_bit_err_i,
    input wire logic fas_valid_i,
    input wire logic fas_good_i,
    input wire logic sync_acquired_i,
    input wire logic [fasi_pkg::ALIGN_W-1:0] sync_alignment_i,
    input wire logic ais_detect_i,
    input wire logic xbit_rai_detect_i,
    input wire logic idle_detect_i,
    input wire logic channel_master_irq_enable_i,
    input wire logic manual_error_insert_input_i,
    output logic [fasi_pkg::N_INSERT-1:0] error_insert_o,
    output logic [1:0] framing_error_type_o,
    output logic channel_irq_o
);
    import fasi_pkg::*;

    logic [DATA_W-1:0] eic, next_eic;
    logic [DATA_W-1:0] irq_en, next_irq_en;
    logic [DATA_W-1:0] latched, next_latched;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] status_word;
    logic [N_STATUS-1:0] status, next_status;
    logic [N_STATUS-1:0] prev_status;
    logic [N_INSERT-1:0] prev_ctl, next_insert;
    logic prev_manual;
    fasi_los_state_t los_state, next_los_state;
    logic [7:0] los_cnt, next_los_cnt;
    logic [F_WIN-1:0] f_win, next_f_win;
    logic [M_WIN-1:0] m_win, next_m_win;
    logic f_over, m_over;
    logic oof, next_oof, sef, next_sef;
    logic [2:0] bad_cnt, next_bad_cnt, good_cnt, next_good_cnt;
    logic have_sync, next_have_sync;
    logic [ALIGN_W-1:0] last_align, next_last_align;
    logic frame_alignment_change_set;
    logic next_irq;
    logic wr_en, latched_clr_hit;

    assign wr_en = reg_cs_i && reg_wr_i;
    assign latched_clr_hit = wr_en && (reg_addr_i == ADDR_LATCHED);
    assign status_word = {{(DATA_W-N_STATUS){1'b0}}, status};
    assign framing_error_type_o = eic[EI_FTYPE_HI:EI_FTYPE_LO];

    // register port; reads have no side effects
    always_comb
    begin
        next_eic = eic;
        next_irq_en = irq_en;
        next_rdata = reg_rdata_o;
        if (wr_en)
        begin
            case (reg_addr_i)
                ADDR_ERR_INSERT: next_eic = reg_wdata_i;
                ADDR_IRQ_EN: next_irq_en = reg_wdata_i & IRQ_EN_MASK;
                default: ;
            endcase
        end
        if (reg_cs_i && reg_rd_i)
        begin
            case (reg_addr_i)
                ADDR_ERR_INSERT: next_rdata = eic;
                ADDR_STATUS: next_rdata = status_word;
                ADDR_LATCHED: next_rdata = latched;
                ADDR_IRQ_EN: next_rdata = irq_en;
                default: next_rdata = RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            eic <= EIC_RESET;
            irq_en <= IRQ_EN_RESET;
            reg_rdata_o <= RDATA_UNMAPPED;
        end
        else
        begin
            eic <= next_eic;
            irq_en <= next_irq_en;
            reg_rdata_o <= next_rdata;
        end
    end

    // error insert trigger; a write that sets a control bit in manual mode
    // is not itself a trigger, only the manual input edge is
    always_comb
    begin
        if (eic[EI_MODE])
        begin
            next_insert = '0;
            if (manual_error_insert_input_i && !prev_manual)
                next_insert = eic[N_INSERT-1:0];
        end
        else
            next_insert = eic[N_INSERT-1:0] & ~prev_ctl;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prev_ctl <= '0;
            prev_manual <= 1'b0;
            error_insert_o <= '0;
        end
        else
        begin
            prev_ctl <= eic[N_INSERT-1:0];
            prev_manual <= manual_error_insert_input_i;
            error_insert_o <= next_insert;
        end
    end

    // loss of signal on the line bit stream
    always_comb
    begin
        next_los_state = los_state;
        next_los_cnt = los_cnt;
        if (line_bit_valid_i)
        begin
            unique case (los_state)
                LOS_CLEAR:
                begin
                    if (line_bit_i)
                        next_los_cnt = '0;
                    else if (los_cnt == LOS_BITS - 8'h01)
                    begin
                        next_los_state = LOS_DECLARED;
                        next_los_cnt = '0;
                    end
                    else
                        next_los_cnt = los_cnt + 8'h01;
                end
                LOS_DECLARED:
                begin
                    if (line_bit_i)
                    begin
                        next_los_state = LOS_RELEASE_WIN;
                        next_los_cnt = 8'h01;
                    end
                end
                LOS_RELEASE_WIN:
                begin
                    // an excess-zero event restarts the wait for a one
                    if (line_exz_i)
                    begin
                        next_los_state = LOS_DECLARED;
                        next_los_cnt = '0;
                    end
                    else if (los_cnt == LOS_BITS - 8'h01)
                    begin
                        next_los_state = LOS_CLEAR;
                        next_los_cnt = '0;
                    end
                    else
                        next_los_cnt = los_cnt + 8'h01;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            los_state <= LOS_CLEAR;
            los_cnt <= '0;
        end
        else
        begin
            los_state <= next_los_state;
            los_cnt <= next_los_cnt;
        end
    end

    // framing alarms; windows restart on resync so a stale error history
    // cannot redeclare out-of-frame right after reacquisition
    assign f_over = ($countones(next_f_win) >= F_ERR_LIMIT);
    assign m_over = ($countones(next_m_win) >= M_ERR_LIMIT);

    always_comb
    begin
        next_f_win = f_win;
        next_m_win = m_win;
        next_oof = oof;
        next_sef = sef;
        next_bad_cnt = bad_cnt;
        next_good_cnt = good_cnt;
        if (!e3_mode_i)
        begin
            if (sync_acquired_i)
            begin
                next_f_win = '0;
                next_m_win = '0;
                next_oof = 1'b0;
            end
            else
            begin
                if (f_bit_valid_i)
                    next_f_win = {f_win[F_WIN-2:0], f_bit_err_i};
                if (m_bit_valid_i)
                    next_m_win = {m_win[M_WIN-2:0], m_bit_err_i};
                if ((f_bit_valid_i && f_over) || (m_bit_valid_i && m_over))
                    next_oof = 1'b1;
            end
            if (f_bit_valid_i && f_over)
                next_sef = 1'b1;
            else if (!next_oof && !f_over)
                next_sef = 1'b0;
        end
        else
        begin
            if (fas_valid_i)
            begin
                if (fas_good_i)
                begin
                    next_bad_cnt = '0;
                    if (good_cnt != E3_GOOD_FAS)
                        next_good_cnt = good_cnt + 3'h1;
                    if (good_cnt + 3'h1 >= E3_GOOD_FAS)
                        next_oof = 1'b0;
                end
                else
                begin
                    next_good_cnt = '0;
                    if (bad_cnt != E3_BAD_FAS)
                        next_bad_cnt = bad_cnt + 3'h1;
                    if (bad_cnt + 3'h1 >= E3_BAD_FAS)
                        next_oof = 1'b1;
                end
            end
            next_sef = next_oof;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            f_win <= '0;
            m_win <= '0;
            oof <= 1'b0;
            sef <= 1'b0;
            bad_cnt <= '0;
            good_cnt <= '0;
        end
        else
        begin
            f_win <= next_f_win;
            m_win <= next_m_win;
            oof <= next_oof;
            sef <= next_sef;
            bad_cnt <= next_bad_cnt;
            good_cnt <= next_good_cnt;
        end
    end

    // live status, change latches and alignment tracking
    always_comb
    begin
        next_status = '0;
        next_status[ST_LOS] = (los_state != LOS_CLEAR) && dual_rail_mode_i;
        next_status[ST_OOF] = oof;
        next_status[ST_AIS] = ais_detect_i;
        next_status[ST_RAI] = xbit_rai_detect_i;
        next_status[ST_IDLE] = idle_detect_i;
        next_status[ST_SEF] = sef;
        next_have_sync = have_sync;
        next_last_align = last_align;
        frame_alignment_change_set = 1'b0;
        if (sync_acquired_i)
        begin
            // only a reacquisition can set it, so a cleared bit stays clear
            frame_alignment_change_set = have_sync && (sync_alignment_i != last_align);
            next_have_sync = 1'b1;
            next_last_align = sync_alignment_i;
        end
        // set wins over a same-cycle clear so no change is lost
        next_latched = latched;
        if (latched_clr_hit)
            next_latched = latched & ~reg_wdata_i;
        next_latched[N_STATUS-1:0] = next_latched[N_STATUS-1:0]
            | (status ^ prev_status);
        next_latched[ST_FRAME_ALIGNMENT_CHANGE] = next_latched[ST_FRAME_ALIGNMENT_CHANGE] | frame_alignment_change_set;
        next_latched = next_latched & LATCHED_MASK;
        next_irq = channel_master_irq_enable_i
            && (|(latched & irq_en));
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            status <= '0;
            prev_status <= '0;
            latched <= LATCHED_RESET;
            have_sync <= 1'b0;
            last_align <= '0;
            channel_irq_o <= 1'b0;
        end
        else
        begin
            status <= next_status;
            prev_status <= status;
            latched <= next_latched;
            have_sync <= next_have_sync;
            last_align <= next_last_align;
            channel_irq_o <= next_irq;
        end
    end

    AST_INSERT_EDGE: assert property (@(posedge clk_i) disable iff (reset_i)
        (!eic[EI_MODE] && eic[EI_BPV] && !prev_ctl[EI_BPV])
        |=> error_insert_o[EI_BPV])
        else $error("control bit rise gave no insert");
    AST_INSERT_MANUAL: assert property (@(posedge clk_i) disable iff (reset_i)
        (eic[EI_MODE] && manual_error_insert_input_i && !prev_manual)
        |=> (error_insert_o == $past(eic[N_INSERT-1:0])))
        else $error("manual edge insert mismatch");
    AST_NO_INSERT: assert property (@(posedge clk_i) disable iff (reset_i)
        (eic[N_INSERT-1:0] == '0) |=> (error_insert_o == '0))
        else $error("insert with all control bits clear");
    AST_STATUS_AIS: assert property (@(posedge clk_i) disable iff (reset_i)
        ais_detect_i ##1 ais_detect_i |-> ##1 status_word[ST_AIS])
        else $error("alarm indication status not shown");
    AST_LOS_BINARY: assert property (@(posedge clk_i) disable iff (reset_i)
        !dual_rail_mode_i |=> !status[ST_LOS])
        else $error("loss status shown in binary mode");
    AST_RAI_SRC: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> (status[ST_RAI] == $past(xbit_rai_detect_i)))
        else $error("remote alarm status not from x bits");
    AST_LATCH_CHANGE: assert property (@(posedge clk_i) disable iff (reset_i)
        (status[ST_OOF] != prev_status[ST_OOF]) |=> latched[ST_OOF])
        else $error("status change not latched");
    AST_W1C_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
        latched_clr_hit |=> ((latched & $past(latched & ~reg_wdata_i))
        == $past(latched & ~reg_wdata_i)))
        else $error("writing zero cleared a latch");
    AST_IRQ_ON: assert property (@(posedge clk_i) disable iff (reset_i)
        (latched[ST_IDLE] && irq_en[ST_IDLE] && channel_master_irq_enable_i)
        |=> channel_irq_o)
        else $error("interrupt not raised");
    AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
        (!channel_master_irq_enable_i || (latched & irq_en) == '0)
        |=> !channel_irq_o)
        else $error("interrupt held without cause");
    AST_FRAME_ALIGNMENT_CHANGE_SET: assert property (@(posedge clk_i) disable iff (reset_i)
        (sync_acquired_i && have_sync && sync_alignment_i != last_align)
        |=> latched[ST_FRAME_ALIGNMENT_CHANGE])
        else $error("alignment change not latched");
    AST_FRAME_ALIGNMENT_CHANGE_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
        (!latched[ST_FRAME_ALIGNMENT_CHANGE] && !sync_acquired_i) |=> !latched[ST_FRAME_ALIGNMENT_CHANGE])
        else $error("alignment latch set without resync");
    AST_EN_BIT6: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_en && reg_addr_i == ADDR_IRQ_EN |=> !irq_en[6])
        else $error("unused enable bit stored");
    AST_LOS_DECLARE: assert property (@(posedge clk_i) disable iff (reset_i)
        (los_state == LOS_CLEAR && los_cnt == LOS_BITS - 8'h01
        && line_bit_valid_i && !line_bit_i) |=> (los_state == LOS_DECLARED))
        else $error("loss not declared at 192 zeros");
    AST_OOF_DS3: assert property (@(posedge clk_i) disable iff (reset_i)
        (!e3_mode_i && !sync_acquired_i && m_bit_valid_i && m_over) |=> oof)
        else $error("ds3 frame loss not declared");
    AST_OOF_E3: assert property (@(posedge clk_i) disable iff (reset_i)
        (e3_mode_i && fas_valid_i && !fas_good_i && bad_cnt == 3'h3)
        |=> (oof && sef))
        else $error("e3 frame loss not declared");
    AST_IRQ_OR: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> (channel_irq_o == $past(channel_master_irq_enable_i
        && (|(latched & irq_en)))))
        else $error("interrupt is not or of enabled latches");
endmodule
`default_nettype wire

// [verif/fasi_framer_model.sv]
// receive framer stand-in: detector strobes, sync pulses, alarm levels
// assumes the bench calls one task at a time from a single process
`timescale 1ns/1ns
`default_nettype none
module fasi_framer_model
    import fasi_pkg::*;
(
    input wire logic clk_i,
    output logic line_v_o,
    output logic line_bit_o,
    output logic line_exz_o,
    output logic f_v_o,
    output logic f_err_o,
    output logic m_v_o,
    output logic m_err_o,
    output logic fas_v_o,
    output logic fas_good_o,
    output logic sync_o,
    output logic [fasi_pkg::ALIGN_W-1:0] align_o,
    output logic ais_o,
    output logic rai_o,
    output logic idle_o
);
    initial
    begin
        {line_v_o, line_bit_o, line_exz_o, f_v_o, f_err_o} = '0;
        {m_v_o, m_err_o, fas_v_o, fas_good_o, sync_o} = '0;
        {align_o, ais_o, rai_o, idle_o} = '0;
    end

    task automatic line(input int n, input logic b, input logic exz);
        repeat (n)
        begin
            @(posedge clk_i);
            line_v_o <= 1'h1;
            line_bit_o <= b;
            line_exz_o <= exz;
        end
        @(posedge clk_i);
        line_v_o <= 1'h0;
        // idle line shows the opposite level so a stale bit cannot count
        line_bit_o <= ~b;
        line_exz_o <= 1'h0;
    endtask

    // kind 0 F bit, 1 M bit, 2 FAS word; flag is error for F/M, good for FAS
    task automatic strobe(input int kind, input int n, input logic flag);
        repeat (n)
        begin
            @(posedge clk_i);
            f_v_o <= (kind == 0);
            m_v_o <= (kind == 1);
            fas_v_o <= (kind == 2);
            {f_err_o, m_err_o, fas_good_o} <= {3{flag}};
        end
        @(posedge clk_i);
        {f_v_o, m_v_o, fas_v_o} <= 3'h0;
        {f_err_o, m_err_o, fas_good_o} <= {3{~flag}};
    endtask

    task automatic sync(input logic [ALIGN_W-1:0] a);
        @(posedge clk_i);
        sync_o <= 1'h1;
        align_o <= a;
        @(posedge clk_i);
        sync_o <= 1'h0;
        align_o <= ~a;
    endtask

    // remote alarm level stands for the X/Sa-bit detector only
    task automatic levels(input logic [2:0] v);
        @(posedge clk_i);
        {idle_o, rai_o, ais_o} <= v;
    endtask
endmodule
`default_nettype wire

// [verif/fasi_alarm_status_irq_tb.sv]
// bench for the channel alarm status, interrupt and error insert block
// assumes the framer model drives all detector inputs
`timescale 1ns/1ns
`default_nettype none
module fasi_alarm_status_irq_tb
    import fasi_pkg::*;
;
`define FASI_CHK(got, exp) begin check_count++; if ((got) !== (exp)) \
    begin err_total++; $display("[FAIL] %0t got %0h exp %0h", $time, \
    (got), (exp)); end end
    int err_total = 0, check_count = 0, ins_cnt = 0;
    logic clk_i, reset_i = 1'h1, reg_cs_i = 1'h0, reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0, dual_rail_mode_i = 1'h1, e3_mode_i = 1'h0;
    logic master = 1'h0, manual = 1'h0, ins_req = 1'h0;
    logic [ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00, reg_rdata_o, exp;
    logic line_bit_valid_i, line_bit_i, line_exz_i, f_bit_valid_i;
    logic f_bit_err_i, m_bit_valid_i, m_bit_err_i, fas_valid_i, fas_good_i;
    logic sync_acquired_i, ais_detect_i, xbit_rai_detect_i, idle_detect_i;
    logic [ALIGN_W-1:0] sync_alignment_i;
    logic [N_INSERT-1:0] error_insert_o, ins_acc = 5'h00;
    logic [1:0] framing_error_type_o;
    logic channel_irq_o;

    fasi_alarm_status_irq dut_u (.clk_i(clk_i), .reset_i(reset_i),
        .reg_cs_i(reg_cs_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .dual_rail_mode_i(dual_rail_mode_i),
        .e3_mode_i(e3_mode_i), .line_bit_valid_i(line_bit_valid_i),
        .line_bit_i(line_bit_i), .line_exz_i(line_exz_i),
        .f_bit_valid_i(f_bit_valid_i), .f_bit_err_i(f_bit_err_i),
        .m_bit_valid_i(m_bit_valid_i), .m_bit_err_i(m_bit_err_i),
        .fas_valid_i(fas_valid_i), .fas_good_i(fas_good_i),
        .sync_acquired_i(sync_acquired_i),
        .sync_alignment_i(sync_alignment_i), .ais_detect_i(ais_detect_i),
        .xbit_rai_detect_i(xbit_rai_detect_i),
        .idle_detect_i(idle_detect_i),
        .channel_master_irq_enable_i(master),
        .manual_error_insert_input_i(manual),
        .error_insert_o(error_insert_o),
        .framing_error_type_o(framing_error_type_o),
        .channel_irq_o(channel_irq_o));

    fasi_framer_model model_u (.clk_i(clk_i), .line_v_o(line_bit_valid_i),
        .line_bit_o(line_bit_i), .line_exz_o(line_exz_i),
        .f_v_o(f_bit_valid_i), .f_err_o(f_bit_err_i),
        .m_v_o(m_bit_valid_i), .m_err_o(m_bit_err_i),
        .fas_v_o(fas_valid_i), .fas_good_o(fas_good_i),
        .sync_o(sync_acquired_i), .align_o(sync_alignment_i),
        .ais_o(ais_detect_i), .rai_o(xbit_rai_detect_i),
        .idle_o(idle_detect_i));

    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // pulses are gathered here so a one-cycle output is never missed
    always @(posedge clk_i)
    begin
        if (ins_req)
            {ins_acc, ins_cnt} <= '0;
        else if (error_insert_o !== 5'h00)
        begin
            ins_acc <= ins_acc | error_insert_o;
            ins_cnt <= ins_cnt + 1;
        end
    end

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        {reg_cs_i, reg_wr_i} <= 2'h3;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        {reg_cs_i, reg_wr_i} <= 2'h0;
    endtask

    task automatic chk_rd(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m = 8'hff);
        @(posedge clk_i);
        {reg_cs_i, reg_rd_i} <= 2'h3;
        reg_addr_i <= a;
        @(posedge clk_i);
        {reg_cs_i, reg_rd_i} <= 2'h0;
        #1;
        `FASI_CHK(reg_rdata_o & m, e)
    endtask

    task automatic ins_clr();
        @(posedge clk_i);
        ins_req <= 1'h1;
        @(posedge clk_i);
        ins_req <= 1'h0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial
    begin
        #100000;
        err_total++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'h0;
        chk_rd(ADDR_IRQ_EN, 8'h00);
        chk_rd(ADDR_LATCHED, 8'h00);
        chk_rd(8'h20, 8'h00);
        wr(ADDR_IRQ_EN, 8'hff);
        chk_rd(ADDR_IRQ_EN, 8'hbf);
        wr(ADDR_STATUS, 8'hff);
        chk_rd(ADDR_STATUS, 8'h00);
        @(posedge clk_i);
        master <= 1'h1;
        // ais, remote alarm (X/Sa only), idle in turn
        for (int i = 0; i < 3; i++)
        begin
            exp = 8'h01 << (ST_AIS + i);
            wr(ADDR_IRQ_EN, exp);
            model_u.levels(3'h1 << i);
            settle(4);
            chk_rd(ADDR_STATUS, exp);
            chk_rd(ADDR_LATCHED, exp);
            `FASI_CHK(channel_irq_o, 1'h1)
            wr(ADDR_LATCHED, 8'h00);
            chk_rd(ADDR_LATCHED, exp);
            wr(ADDR_LATCHED, exp);
            settle(2);
            `FASI_CHK(channel_irq_o, 1'h0)
            chk_rd(ADDR_LATCHED, 8'h00);
            model_u.levels(3'h0);
            settle(4);
            chk_rd(ADDR_LATCHED, exp);
            wr(ADDR_IRQ_EN, 8'h80);
            settle(2);
            `FASI_CHK(channel_irq_o, 1'h0)
            wr(ADDR_IRQ_EN, exp);
            settle(2);
            `FASI_CHK(channel_irq_o, 1'h1)
            @(posedge clk_i);
            master <= 1'h0;
            settle(2);
            `FASI_CHK(channel_irq_o, 1'h0)
            @(posedge clk_i);
            master <= 1'h1;
            wr(ADDR_LATCHED, exp);
        end
        model_u.line(191, 1'h0, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00);
        model_u.line(1, 1'h0, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h01);
        model_u.line(1, 1'h1, 1'h0);
        model_u.line(40, 1'h0, 1'h0);
        model_u.line(1, 1'h0, 1'h1);
        model_u.line(160, 1'h0, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h01);
        model_u.line(1, 1'h1, 1'h0);
        model_u.line(190, 1'h0, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h01);
        model_u.line(1, 1'h0, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00);
        model_u.line(192, 1'h0, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h01);
        @(posedge clk_i);
        dual_rail_mode_i <= 1'h0;
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00);
        wr(ADDR_LATCHED, 8'hff);
        model_u.strobe(0, 2, 1'h1);
        model_u.strobe(0, 5, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00);
        model_u.strobe(0, 1, 1'h1);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h22);
        model_u.sync(13'h0005);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00);
        chk_rd(ADDR_LATCHED, 8'h22);
        model_u.strobe(1, 1, 1'h1);
        model_u.strobe(1, 1, 1'h0);
        model_u.strobe(1, 1, 1'h1);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h02);
        model_u.sync(13'h0005);
        settle(2);
        chk_rd(ADDR_LATCHED, 8'h00, 8'h80);
        wr(ADDR_LATCHED, 8'hff);
        model_u.sync(13'h0009);
        settle(2);
        chk_rd(ADDR_LATCHED, 8'h80);
        wr(ADDR_LATCHED, 8'h80);
        model_u.sync(13'h0009);
        settle(2);
        chk_rd(ADDR_LATCHED, 8'h00);
        @(posedge clk_i);
        e3_mode_i <= 1'h1;
        // idle status carries no meaning in E3 and is masked off
        model_u.strobe(2, 3, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00, 8'hef);
        model_u.strobe(2, 1, 1'h0);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h22, 8'hef);
        model_u.strobe(2, 2, 1'h1);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h22, 8'hef);
        model_u.strobe(2, 1, 1'h1);
        settle(2);
        chk_rd(ADDR_STATUS, 8'h00, 8'hef);
        ins_clr();
        wr(ADDR_ERR_INSERT, 8'h01);
        settle(4);
        `FASI_CHK(ins_acc, 5'h01)
        ins_clr();
        wr(ADDR_ERR_INSERT, 8'h1f);
        settle(4);
        `FASI_CHK(ins_acc, 5'h1e)
        `FASI_CHK(ins_cnt, 1)
        ins_clr();
        wr(ADDR_ERR_INSERT, 8'h80);
        wr(ADDR_ERR_INSERT, 8'h85);
        settle(4);
        `FASI_CHK(ins_cnt, 0)
        @(posedge clk_i) manual <= 1'h1;
        settle(4);
        `FASI_CHK(ins_acc, 5'h05)
        `FASI_CHK(ins_cnt, 1)
        @(posedge clk_i) manual <= 1'h0;
        ins_clr();
        wr(ADDR_ERR_INSERT, 8'h80);
        settle(2);
        @(posedge clk_i) manual <= 1'h1;
        settle(4);
        `FASI_CHK(ins_cnt, 0)
        wr(ADDR_ERR_INSERT, 8'h60);
        chk_rd(ADDR_ERR_INSERT, 8'h60);
        `FASI_CHK(framing_error_type_o, 2'h3)
        close_out();
    end
endmodule
`default_nettype wire
